/* pkg/mmp_pkg.sv */
/*
  mmp_pkg: address map, register offsets, reset values and carrier
  types of the memory map and port register block.
  assumes: an 8-bit data, 16-bit address processor bus.
*/
`default_nettype none
package mmp_pkg;
  localparam int MMP_ADDR_W = 16;
  localparam int MMP_DATA_W = 8;
  // region bounds
  localparam logic [15:0] MMP_IO_LO = 16'h0000;
  localparam logic [15:0] MMP_IO_HI = 16'h003F;
  localparam logic [15:0] MMP_RAM_LO = 16'h0040;
  localparam logic [15:0] MMP_RAM_HI = 16'h023F;
  localparam logic [15:0] MMP_FLASH_LO = 16'h8000;
  localparam logic [15:0] MMP_FLASH_HI = 16'hFDFF;
  localparam logic [15:0] MMP_SYS_LO = 16'hFE00;
  localparam logic [15:0] MMP_SYS_HI = 16'hFE0C;
  localparam logic [15:0] MMP_SYS_RSV_A = 16'hFE02;
  localparam logic [15:0] MMP_SYS_RSV_B = 16'hFE07;
  localparam logic [15:0] MMP_ROM_LO = 16'hFE20;
  localparam logic [15:0] MMP_ROM_HI = 16'hFF52;
  localparam logic [15:0] MMP_PROTECT = 16'hFF7E;
  localparam logic [15:0] MMP_VEC_LO = 16'hFFDC;
  localparam logic [15:0] MMP_SEC_LO = 16'hFFF6;
  localparam logic [15:0] MMP_SEC_HI = 16'hFFFD;
  localparam logic [15:0] MMP_WATCHDOG = 16'hFFFF;
  // port register offsets
  localparam logic [15:0] MMP_OFF_A_PINS = 16'h0000;
  localparam logic [15:0] MMP_OFF_B_PINS = 16'h0001;
  localparam logic [15:0] MMP_OFF_C_PINS = 16'h0002;
  localparam logic [15:0] MMP_OFF_D_PINS = 16'h0003;
  localparam logic [15:0] MMP_OFF_A_DIR = 16'h0004;
  localparam logic [15:0] MMP_OFF_B_DIR = 16'h0005;
  localparam logic [15:0] MMP_OFF_C_DIR = 16'h0006;
  localparam logic [15:0] MMP_OFF_D_DIR = 16'h0007;
  localparam logic [15:0] MMP_OFF_E_PINS = 16'h0008;
  localparam logic [15:0] MMP_OFF_UNIMP_LO = 16'h0009;
  localparam logic [15:0] MMP_OFF_UNIMP_HI = 16'h000B;
  localparam logic [15:0] MMP_OFF_E_DIR = 16'h000C;
  localparam logic [15:0] MMP_OFF_A_PUE = 16'h000D;
  // widths and reset values
  localparam int MMP_C_W = 7;
  localparam int MMP_E_W = 2;
  localparam logic [7:0] MMP_DIR_RST = 8'h00;
  localparam logic [7:0] MMP_PUE_RST = 8'h00;
  localparam logic [7:0] MMP_RD_ZERO = 8'h00;

  // decoded region of one access
  typedef enum logic [3:0] {
    MMP_RG_UNIMP = 4'h0,
    MMP_RG_IO_PORT = 4'h1,
    MMP_RG_IO_UNIMP = 4'h2,
    MMP_RG_IO_OTHER = 4'h3,
    MMP_RG_RAM = 4'h4,
    MMP_RG_FLASH = 4'h5,
    MMP_RG_SYSREG = 4'h6,
    MMP_RG_SYS_RSV = 4'h7,
    MMP_RG_ROM = 4'h8,
    MMP_RG_PROTECT = 4'h9,
    MMP_RG_VECTOR = 4'hA,
    MMP_RG_SECURITY = 4'hB,
    MMP_RG_WATCHDOG = 4'hC
  } mmp_region_t;

  // request from the processor core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mmp_req_t;

  // access forwarded to the selected region
  typedef struct packed {
    mmp_region_t region;
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mmp_sel_t;
endpackage
`default_nettype wire

/* rtl/mmp_decode.sv */
/*
  mmp_decode: combinational address decoder, one region per address.
  assumes: caller registers the result; same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module mmp_decode (
  // address in
  input wire logic [15:0] addr,
  // region out
  output mmp_pkg::mmp_region_t region
);
  import mmp_pkg::*;

  // priority order: narrow windows before the ranges that hold them
  always_comb begin
    if (addr <= MMP_IO_HI) begin
      if (addr <= MMP_OFF_E_PINS || addr == MMP_OFF_E_DIR || addr == MMP_OFF_A_PUE) begin
        region = MMP_RG_IO_PORT;
      end else if (addr >= MMP_OFF_UNIMP_LO && addr <= MMP_OFF_UNIMP_HI) begin
        region = MMP_RG_IO_UNIMP;
      end else begin
        region = MMP_RG_IO_OTHER;
      end
    end else if (addr >= MMP_RAM_LO && addr <= MMP_RAM_HI) begin
      region = MMP_RG_RAM;
    end else if (addr >= MMP_FLASH_LO && addr <= MMP_FLASH_HI) begin
      region = MMP_RG_FLASH;
    end else if (addr == MMP_SYS_RSV_A || addr == MMP_SYS_RSV_B) begin
      region = MMP_RG_SYS_RSV;
    end else if (addr >= MMP_SYS_LO && addr <= MMP_SYS_HI) begin
      region = MMP_RG_SYSREG;
    end else if (addr >= MMP_ROM_LO && addr <= MMP_ROM_HI) begin
      region = MMP_RG_ROM;
    end else if (addr == MMP_PROTECT) begin
      region = MMP_RG_PROTECT;
    end else if (addr == MMP_WATCHDOG) begin
      region = MMP_RG_WATCHDOG;
    end else if (addr >= MMP_SEC_LO && addr <= MMP_SEC_HI) begin
      region = MMP_RG_SECURITY;
    end else if (addr >= MMP_VEC_LO) begin
      region = MMP_RG_VECTOR;
    end else begin
      // gaps: $0240-$7FFF, $FE0D-$FE1F, $FF53-$FF7D, $FF7F-$FFDB
      region = MMP_RG_UNIMP;
    end
  end
endmodule
`default_nettype wire

/* rtl/mmp_port.sv */
/*
  mmp_port: one parallel port of W pins: data latch, direction,
  pull-up enable, pin synchroniser and read-back value.
  assumes: write enables are one-cycle pulses on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module mmp_port #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // register writes
  input wire logic wr_data,
  input wire logic wr_dir,
  input wire logic wr_pue,
  input wire logic [W-1:0] wdata,
  // pins
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe,
  output logic [W-1:0] pullup_q,
  // read-back
  output logic [W-1:0] rd_data,
  output logic [W-1:0] pue_q
);
  import mmp_pkg::*;

  logic [W-1:0] data_q; // output latch, no reset
  logic [W-1:0] dir_q;  // one = output
  logic [W-1:0] pin_q;  // debounced pin level

  // data latch keeps its value through reset
  always_ff @(posedge clock) begin
    if (wr_data) begin
      data_q <= wdata;
    end
  end

  // direction clears on reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dir_q <= MMP_DIR_RST[W-1:0];
    end else if (wr_dir) begin
      dir_q <= wdata;
    end
  end

  // pull-up enable bits
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pue_q <= MMP_PUE_RST[W-1:0];
    end else if (wr_pue) begin
      pue_q <= wdata;
    end
  end

  // R19: pull-up only while input
  // built from the next enable and direction, so the pull-up drops in
  // the same cycle the pin turns into an output, never one cycle late
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pullup_q <= MMP_PUE_RST[W-1:0];
    end else begin
      pullup_q <= (wr_pue ? wdata : pue_q) & ~(wr_dir ? wdata : dir_q);
    end
  end

  assign pin_out = data_q;
  assign pin_oe = dir_q;

  // per pin: three-stage sync, accept a level once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_pin
    logic s1_q, s2_q, s3_q;
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        pin_q[i] <= 1'b0;
      end else begin
        s1_q <= pin_in[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          pin_q[i] <= s3_q;
        end
      end
    end
    // R20: outputs read the latch
    assign rd_data[i] = dir_q[i] ? data_q[i] : pin_q[i];
  end
endmodule
`default_nettype wire

/* rtl/mmp_top.sv */
/*
  mmp_top: memory map decoder and zero-page port registers.
  Decodes every processor access, answers reads of the port
  registers itself, forwards every access to the selected region and
  asks for an illegal-address reset on unimplemented locations.
  assumes: one clock; rd/wr are single-cycle strobes from the core;
  pin inputs are asynchronous and pass the port synchronisers.
*/
//
// Contract
// R1: decode 16-bit address, 64 Kbyte space
// R2: flag unimplemented access, request illegal reset
// R3: core avoids reserved locations
// R4: zero-page registers at $0000-$003F
// R5: RAM $0040-$023F, $0240-$7FFF unimplemented
// R6: user flash at $8000-$FDFF
// R7: system registers $FE00-$FE0C, two reserved
// R8: $FE0D-$FE1F unimplemented
// R9: monitor ROM $FE20-$FF52, then gap
// R10: flash protect at $FF7E, then gap
// R11: vector area $FFDC-$FFFF
// R12: security bytes $FFF6-$FFFD
// R13: watchdog control shares $FFFF
// R14: ports A, B, D data kept through reset
// R15: port C seven bits, bit 7 zero
// R16: A, B, D direction cleared by reset
// R17: port E two bits, upper zero
// R18: port A pull-up enables, reset clear
// R19: pull-up off while pin is output
// R20: direction one drives latch, else pin read
// R21: $0009-$000B read zero, writes ignored
`timescale 1ns/100ps
`default_nettype none
module mmp_top (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // processor request
  input wire mmp_pkg::mmp_req_t req,
  // answer and forwarding
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  output mmp_pkg::mmp_sel_t sel_q,
  output logic illegal_rst_q,
  output logic reserved_hit_q,
  // port A
  input wire logic [7:0] pin_a_in,
  output logic [7:0] pin_a_out,
  output logic [7:0] pin_a_oe,
  output logic [7:0] pin_a_pullup,
  // port B
  input wire logic [7:0] pin_b_in,
  output logic [7:0] pin_b_out,
  output logic [7:0] pin_b_oe,
  // port C
  input wire logic [6:0] pin_c_in,
  output logic [6:0] pin_c_out,
  output logic [6:0] pin_c_oe,
  // port D
  input wire logic [7:0] pin_d_in,
  output logic [7:0] pin_d_out,
  output logic [7:0] pin_d_oe,
  // port E
  input wire logic [1:0] pin_e_in,
  output logic [1:0] pin_e_out,
  output logic [1:0] pin_e_oe
);
  import mmp_pkg::*;

  mmp_region_t region; // region of the current request
  logic access;        // a read or a write this cycle
  logic io_wr;         // write that lands on a port register
  logic io_rd;         // read answered here
  logic [7:0] rd_mux;  // read value before the answer flop

  // read-back from each port
  logic [7:0] a_rd, b_rd, d_rd, a_pue;
  logic [6:0] c_rd;
  logic [1:0] e_rd;

  // write strobes, one per register
  logic wa_d, wb_d, wc_d, wd_d, we_d;
  logic wa_r, wb_r, wc_r, wd_r, we_r;
  logic wa_p;

  // R1: whole 16-bit space decoded
  mmp_decode u_decode (
    .addr(req.addr),
    .region(region)
  );

  assign access = req.rd | req.wr;
  // R4: port registers live in zero page
  assign io_wr = req.wr && (region == MMP_RG_IO_PORT);
  // unimplemented zero-page bytes are answered here too
  assign io_rd = req.rd && (region == MMP_RG_IO_PORT || region == MMP_RG_IO_UNIMP);

  // write strobes; R21: nothing decodes $0009-$000B
  assign wa_d = io_wr && req.addr == MMP_OFF_A_PINS;
  assign wb_d = io_wr && req.addr == MMP_OFF_B_PINS;
  assign wc_d = io_wr && req.addr == MMP_OFF_C_PINS;
  assign wd_d = io_wr && req.addr == MMP_OFF_D_PINS;
  assign we_d = io_wr && req.addr == MMP_OFF_E_PINS;
  assign wa_r = io_wr && req.addr == MMP_OFF_A_DIR;
  assign wb_r = io_wr && req.addr == MMP_OFF_B_DIR;
  assign wc_r = io_wr && req.addr == MMP_OFF_C_DIR;
  assign wd_r = io_wr && req.addr == MMP_OFF_D_DIR;
  assign we_r = io_wr && req.addr == MMP_OFF_E_DIR;
  assign wa_p = io_wr && req.addr == MMP_OFF_A_PUE;

  // R14: ports A, B, D full width
  // R16: their direction registers
  // R18: only port A carries pull-ups here
  mmp_port #(.W(8)) u_port_a (
    .clock(clock),
    .rstn(rstn),
    .wr_data(wa_d),
    .wr_dir(wa_r),
    .wr_pue(wa_p),
    .wdata(req.wdata),
    .pin_in(pin_a_in),
    .pin_out(pin_a_out),
    .pin_oe(pin_a_oe),
    .pullup_q(pin_a_pullup),
    .rd_data(a_rd),
    .pue_q(a_pue)
  );

  mmp_port #(.W(8)) u_port_b (
    .clock(clock),
    .rstn(rstn),
    .wr_data(wb_d),
    .wr_dir(wb_r),
    .wr_pue(1'b0),
    .wdata(req.wdata),
    .pin_in(pin_b_in),
    .pin_out(pin_b_out),
    .pin_oe(pin_b_oe),
    .pullup_q(),
    .rd_data(b_rd),
    .pue_q()
  );

  // R15: port C keeps bits 6..0 only
  mmp_port #(.W(MMP_C_W)) u_port_c (
    .clock(clock),
    .rstn(rstn),
    .wr_data(wc_d),
    .wr_dir(wc_r),
    .wr_pue(1'b0),
    .wdata(req.wdata[6:0]),
    .pin_in(pin_c_in),
    .pin_out(pin_c_out),
    .pin_oe(pin_c_oe),
    .pullup_q(),
    .rd_data(c_rd),
    .pue_q()
  );

  mmp_port #(.W(8)) u_port_d (
    .clock(clock),
    .rstn(rstn),
    .wr_data(wd_d),
    .wr_dir(wd_r),
    .wr_pue(1'b0),
    .wdata(req.wdata),
    .pin_in(pin_d_in),
    .pin_out(pin_d_out),
    .pin_oe(pin_d_oe),
    .pullup_q(),
    .rd_data(d_rd),
    .pue_q()
  );

  // R17: port E keeps bits 1..0 only
  mmp_port #(.W(MMP_E_W)) u_port_e (
    .clock(clock),
    .rstn(rstn),
    .wr_data(we_d),
    .wr_dir(we_r),
    .wr_pue(1'b0),
    .wdata(req.wdata[1:0]),
    .pin_in(pin_e_in),
    .pin_out(pin_e_out),
    .pin_oe(pin_e_oe),
    .pullup_q(),
    .rd_data(e_rd),
    .pue_q()
  );

  // read mux; narrow ports pad with zeros above their pins
  always_comb begin
    rd_mux = MMP_RD_ZERO;
    case (req.addr)
      MMP_OFF_A_PINS: rd_mux = a_rd;
      MMP_OFF_B_PINS: rd_mux = b_rd;
      // R15: bit 7 reads zero
      MMP_OFF_C_PINS: rd_mux = {1'b0, c_rd};
      MMP_OFF_D_PINS: rd_mux = d_rd;
      MMP_OFF_A_DIR: rd_mux = pin_a_oe;
      MMP_OFF_B_DIR: rd_mux = pin_b_oe;
      MMP_OFF_C_DIR: rd_mux = {1'b0, pin_c_oe};
      MMP_OFF_D_DIR: rd_mux = pin_d_oe;
      // R17: upper bits read zero
      MMP_OFF_E_PINS: rd_mux = {6'b00_0000, e_rd};
      MMP_OFF_E_DIR: rd_mux = {6'b00_0000, pin_e_oe};
      MMP_OFF_A_PUE: rd_mux = a_pue;
      // R21: unimplemented bytes read zero
      default: rd_mux = MMP_RD_ZERO;
    endcase
  end

  // read answer: one cycle after the strobe, zero when not ours
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= MMP_RD_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= io_rd;
      rdata_q <= io_rd ? rd_mux : MMP_RD_ZERO;
    end
  end

  // forward every access with its region so memories can respond
  // R5: RAM, R6: flash, R9: ROM, R10: protect register
  // R11: vectors, R12: security, R13: watchdog at the top byte
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sel_q <= '0;
    end else begin
      sel_q.region <= region;
      sel_q.rd <= req.rd;
      sel_q.wr <= req.wr;
      sel_q.addr <= req.addr;
      sel_q.wdata <= req.wdata;
    end
  end

  // R2: unimplemented hit raises a one-cycle reset request
  // R8: $FE0D-$FE1F fall into the unimplemented region
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      illegal_rst_q <= 1'b0;
    end else begin
      illegal_rst_q <= access && (region == MMP_RG_UNIMP || region == MMP_RG_IO_UNIMP);
    end
  end

  // R3: reserved hits are only reported; the core must avoid them
  // R7: $FE02 and $FE07 are the reserved system slots
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reserved_hit_q <= 1'b0;
    end else begin
      reserved_hit_q <= access && (region == MMP_RG_SYS_RSV);
    end
  end

  // checks on the answers driven by this block
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_wr_a_data;
    req.wr && req.addr == MMP_OFF_A_PINS;
  endsequence

  sequence s_rd_unimp;
    req.rd && req.addr >= MMP_OFF_UNIMP_LO && req.addr <= MMP_OFF_UNIMP_HI;
  endsequence

  a_read_answer_once: assert property (io_rd |=> rvalid_q ##1 (!rvalid_q || $past(io_rd))) // R20
    else $error("port read not answered in one cycle");
  a_unimp_read_zero: assert property (s_rd_unimp |=> rvalid_q && rdata_q == 8'h00) // R21
    else $error("unimplemented zero-page read not zero");
  a_unimp_reset_req: assert property (s_rd_unimp |=> illegal_rst_q) // R2
    else $error("no reset request on unimplemented access");
  a_gap_reset_req: assert property (access && req.addr >= 16'h0240 && req.addr <= 16'h7FFF
    |=> illegal_rst_q && sel_q.region == MMP_RG_UNIMP) // R5
    else $error("gap access not flagged");
  a_ram_forwarded: assert property (req.rd && region == MMP_RG_RAM
    |=> sel_q.rd && sel_q.region == MMP_RG_RAM && !illegal_rst_q) // R5
    else $error("RAM read not forwarded");
  a_latch_drives_pin: assert property (s_wr_a_data |=> pin_a_out == $past(req.wdata)) // R20
    else $error("port A latch not updated");
  a_pullup_gated: assert property ((pin_a_pullup & pin_a_oe) == 8'h00) // R19
    else $error("pull-up active on an output pin");
  a_c_top_bit: assert property (req.rd && req.addr == MMP_OFF_C_PINS |=> !rdata_q[7]) // R15
    else $error("port C bit 7 not zero");
  a_e_upper_zero: assert property (req.rd && req.addr == MMP_OFF_E_DIR
    |=> rdata_q[7:2] == 6'b00_0000 && rdata_q[1:0] == pin_e_oe) // R17
    else $error("port E direction read-back wrong");
  a_watchdog_top: assert property (access && req.addr == 16'hFFFF
    |=> sel_q.region == MMP_RG_WATCHDOG) // R13
    else $error("top byte not decoded as watchdog");
  a_reserved_flag: assert property (access && req.addr == 16'hFE07 |=> reserved_hit_q) // R7
    else $error("reserved slot not flagged");
endmodule
`default_nettype wire

/* test/memory_map_port_registers_tb.sv */
/*
  memory_map_port_registers_tb: drives mmp_top through the core model
  and compares every answer, save the read data of port registers in the decode test, with a bench model of map and ports.
  assumes: pins settle within six cycles through the synchronisers.
*/
`timescale 1ns/100ps
`default_nettype none
module memory_map_port_registers_tb;
  import mmp_pkg::*;
  logic clock, rstn;
  mmp_req_t req;
  mmp_sel_t sel_q;
  logic [7:0] rdata_q, rd, d;
  logic rvalid_q, illegal_rst_q, reserved_hit_q;
  logic [7:0] pin_a_pullup, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, pin_d_out, pin_d_oe;
  logic [6:0] pin_c_out, pin_c_oe;
  logic [1:0] pin_e_out, pin_e_oe;
  int miscompares, checked;
  // bench model: latch, direction, pull-up enable, pin levels
  logic [7:0] lat [5], dir [5], pin [5], pout [5], poe [5], pue;
  logic [7:0] msk [5] = '{8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h03};
  logic [15:0] dadr [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0008};
  logic [15:0] radr [5] = '{16'h0004, 16'h0005, 16'h0006, 16'h0007, 16'h000C};
  logic [15:0] tab [33] = '{16'h0000, 16'h0008, 16'h0009, 16'h000B, 16'h000C, 16'h000D,
    16'h000E, 16'h003F, 16'h0040, 16'h023F, 16'h0240, 16'h7FFF, 16'h8000, 16'hFDFF,
    16'hFE00, 16'hFE02, 16'hFE07, 16'hFE0C, 16'hFE0D, 16'hFE1F, 16'hFE20, 16'hFF52,
    16'hFF53, 16'hFF7D, 16'hFF7E, 16'hFF7F, 16'hFFDB, 16'hFFDC, 16'hFFF5, 16'hFFF6,
    16'hFFFD, 16'hFFFE, 16'hFFFF};
  // narrow ports widened so one loop covers all five
  assign pout = '{pin_a_out, pin_b_out, {1'b0, pin_c_out}, pin_d_out, {6'h00, pin_e_out}};
  assign poe = '{pin_a_oe, pin_b_oe, {1'b0, pin_c_oe}, pin_d_oe, {6'h00, pin_e_oe}};

  mmp_core_model core_u (.clock(clock), .req(req), .rdata_q(rdata_q));
  mmp_top dut_u (.clock(clock), .rstn(rstn), .req(req), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q), .sel_q(sel_q), .illegal_rst_q(illegal_rst_q),
    .reserved_hit_q(reserved_hit_q), .pin_a_in(pin[0]), .pin_a_out(pin_a_out),
    .pin_a_oe(pin_a_oe), .pin_a_pullup(pin_a_pullup), .pin_b_in(pin[1]),
    .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .pin_c_in(pin[2][6:0]),
    .pin_c_out(pin_c_out), .pin_c_oe(pin_c_oe), .pin_d_in(pin[3]),
    .pin_d_out(pin_d_out), .pin_d_oe(pin_d_oe), .pin_e_in(pin[4][1:0]),
    .pin_e_out(pin_e_out), .pin_e_oe(pin_e_oe));

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // expected region, written from the map independently of the decoder
  function automatic mmp_region_t exp_rg(input logic [15:0] a);
    if (a <= 16'h0008 || a == 16'h000C || a == 16'h000D) return MMP_RG_IO_PORT;
    if (a <= 16'h000B) return MMP_RG_IO_UNIMP;
    if (a <= 16'h003F) return MMP_RG_IO_OTHER;
    if (a <= 16'h023F) return MMP_RG_RAM;
    if (a < 16'h8000) return MMP_RG_UNIMP;
    if (a <= 16'hFDFF) return MMP_RG_FLASH;
    if (a == 16'hFE02 || a == 16'hFE07) return MMP_RG_SYS_RSV;
    if (a <= 16'hFE0C) return MMP_RG_SYSREG;
    if (a < 16'hFE20) return MMP_RG_UNIMP;
    if (a <= 16'hFF52) return MMP_RG_ROM;
    if (a == 16'hFF7E) return MMP_RG_PROTECT;
    if (a < 16'hFFDC) return MMP_RG_UNIMP;
    if (a == 16'hFFFF) return MMP_RG_WATCHDOG;
    if (a >= 16'hFFF6 && a <= 16'hFFFD) return MMP_RG_SECURITY;
    return MMP_RG_VECTOR;
  endfunction

  // byte and flag results
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // decoded region results
  task automatic chk_rg(input mmp_region_t got, input mmp_region_t exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one read and its routing, flags and copied address
  task automatic do_dec(input logic [15:0] a);
    mmp_region_t r;
    r = exp_rg(a);
    core_u.xfer(1'b0, a, 8'h00, rd);
    chk_rg(sel_q.region, r);
    chk8({7'h00, illegal_rst_q}, {7'h00, r == MMP_RG_UNIMP || r == MMP_RG_IO_UNIMP});
    chk8({7'h00, reserved_hit_q}, {7'h00, r == MMP_RG_SYS_RSV});
    chk8({6'h00, sel_q.wr, sel_q.rd}, 8'h01);
    chk8(sel_q.wdata, 8'h00);
    chk8(sel_q.addr[15:8], a[15:8]);
    chk8(sel_q.addr[7:0], a[7:0]);
    if (r != MMP_RG_IO_PORT) chk8(rd, 8'h00);
  endtask

  // port pins and registers against the model
  task automatic check_ports();
    for (int p = 0; p < 5; p++) begin
      chk8(pout[p], lat[p]);
      chk8(poe[p], dir[p]);
      core_u.xfer(1'b0, dadr[p], 8'h00, rd);
      chk8(rd, (lat[p] & dir[p]) | (pin[p] & ~dir[p] & msk[p]));
      core_u.xfer(1'b0, radr[p], 8'h00, rd);
      chk8(rd, dir[p]);
    end
    chk8(pin_a_pullup, pue & ~dir[0]);
    core_u.xfer(1'b0, 16'h000D, 8'h00, rd);
    chk8(rd, pue);
    core_u.xfer(1'b0, 16'h000A, 8'h00, rd);
    chk8(rd, 8'h00);
  endtask

  // counts and verdict; the single end of the run
  task automatic summarize();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard
  initial begin
    #400000;
    miscompares++;
    summarize();
  end

  // main sequence
  initial begin
    miscompares = 0;
    checked = 0;
    rstn = 1'b0;
    pin = '{default: 8'h00};
    void'($urandom(32'h34f0));
    repeat (3) @(posedge clock);
    #1 rstn = 1'b1;
    for (int p = 0; p < 5; p++) begin
      core_u.xfer(1'b0, radr[p], 8'h00, rd);
      chk8(rd, 8'h00);
      chk8({7'h00, rvalid_q}, 8'h01);
    end
    @(posedge clock);
    #1;
    chk8({7'h00, rvalid_q}, 8'h00);
    $display("test reset_values done");
    foreach (tab[i]) do_dec(tab[i]);
    for (int n = 0; n < 40; n++) begin
      d = 8'($urandom);
      // random reads stay off the reserved bytes
      do_dec((16'($urandom) | 16'h0100) ^ {8'h00, d & 8'h00});
    end
    $display("test decode done");
    for (int n = 0; n < 8; n++) begin
      for (int p = 0; p < 5; p++) begin
        pin[p] = 8'($urandom);
        d = 8'($urandom);
        core_u.xfer(1'b1, dadr[p], d, rd);
        chk8({6'h00, sel_q.wr, sel_q.rd}, 8'h02);
        chk8(sel_q.wdata, d);
        lat[p] = d & msk[p];
        d = 8'($urandom);
        core_u.xfer(1'b1, radr[p], d, rd);
        dir[p] = d & msk[p];
      end
      d = 8'($urandom);
      core_u.xfer(1'b1, 16'h000D, d, rd);
      pue = d;
      core_u.xfer(1'b1, 16'h0009 + 16'(n % 3), 8'hFF, rd);
      repeat (6) @(posedge clock);
      #1;
      check_ports();
    end
    $display("test port_registers done");
    // reset in mid-run: latches kept, direction and pull-ups cleared
    @(posedge clock);
    #1 rstn = 1'b0;
    repeat (2) @(posedge clock);
    #1 rstn = 1'b1;
    dir = '{default: 8'h00};
    pue = 8'h00;
    repeat (6) @(posedge clock);
    #1;
    check_ports();
    $display("test mid_reset done");
    summarize();
  end
endmodule
`default_nettype wire

/* test/mmp_core_model.sv */
/*
  mmp_core_model: behavioural processor core issuing byte reads and
  writes, one strobe per access.
  assumes: mmp_top takes a strobe on a rising edge and answers one
  cycle later; the bench calls xfer from a single process.
*/
`timescale 1ns/100ps
`default_nettype none
module mmp_core_model (
  // clock
  input wire logic clock,
  // request out
  output var mmp_pkg::mmp_req_t req,
  // answer in
  input wire logic [7:0] rdata_q
);
  import mmp_pkg::*;
  // idle bus at time zero
  initial req = '{rd: 1'b0, wr: 1'b0, addr: 16'hFFFF, wdata: 8'hFF};
  // one access: drive after an edge, hold through the taking edge
  // reserved places reached only when the caller names one
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] rd);
    @(posedge clock);
    #1;
    req = '{rd: ~w, wr: w, addr: a, wdata: d};
    @(posedge clock);
    #1;
    rd = rdata_q;
    // a released bus shows the inverse, so stale values never match
    req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire
